/* File: design/stack_push_pop_unit.sv */
// stack push/pop sequencer with far-call ordering and stack pointer backup
`timescale 1ns/100ps
`default_nettype none
`include "stack_unit_defines.svh"

module stack_push_pop_unit
	import stack_unit_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic        cmd_valid_i,
	input  wire stack_cmd_t  cmd_i,
	output logic             cmd_ready_o,
	input  wire stack_mode_t mode_i,
	input  wire logic        sp_wr_i,
	input  wire logic [31:0] sp_wr_data_i,
	output var mem_req_t     mem_req_o,
	input  wire logic        mem_ack_i,
	input  wire logic [31:0] mem_rdata_i,
	input  wire logic        mem_fault_i,
	output logic             br_req_o,
	input  wire logic        br_done_i,
	input  wire logic        br_limit_viol_i,
	input  wire logic        br_rights_viol_i,
	output logic             done_o,
	output logic             fault_o,
	output fault_t           fault_code_o,
	output logic [31:0]      sp_o,
	output logic [31:0]      pop_data_o
);

	// ==================================================================
	// reset release
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_reg[1];

	// ==================================================================
	// helpers
	function automatic logic [31:0] sp_step(
		input logic [31:0] sp,
		input logic [31:0] delta,
		input logic        down,
		input logic        wide
	);
		logic [31:0] r;
		r = down ? (sp - delta) : (sp + delta);
		// 16-bit stack: only the low half moves, wrap stays inside 64 KB
		sp_step = wide ? r : {sp[31:16], r[15:0]};
	endfunction : sp_step

	function automatic logic [31:0] op_delta(input logic wide_op);
		op_delta = wide_op ? `SU_DELTA_WORD : `SU_DELTA_HALF;
	endfunction : op_delta

	function automatic logic [3:0] op_be(input logic wide_op);
		op_be = wide_op ? `SU_BE_WORD : `SU_BE_HALF;
	endfunction : op_be

	// ==================================================================
	// state
	stack_state_t state_reg, state_next;
	stack_cmd_t   cmd_reg, cmd_next;
	stack_mode_t  mode_reg, mode_next;
	logic [31:0]  sp_reg, sp_next;
	logic [31:0]  save_reg, save_next;
	logic [31:0]  data_reg, data_next;
	fault_t       fcode_reg, fcode_next;

	mem_req_t     req;
	logic         access;
	logic         lim_fault;
	logic         branch_fault;
	logic [31:0]  sp_addr;

	assign access       = (state_reg == ST_PUSH) || (state_reg == ST_PUSH2) ||
	                      (state_reg == ST_READ) || (state_reg == ST_WRITE);
	assign branch_fault = br_limit_viol_i || br_rights_viol_i;
	assign sp_addr      = mode_reg.stack32 ? sp_reg : {`SU_ZERO_HALF, sp_reg[15:0]};

	// ==================================================================
	// request forming
	always_comb begin
		req           = '0;
		req.stack_seg = 1'b1;
		req.addr      = sp_addr;
		case (state_reg)
			ST_PUSH: begin
				req.write = 1'b1;
				if (cmd_reg.op == OP_PUSH_ERR) begin
					req.wdata = {`SU_ZERO_HALF, cmd_reg.value[15:0]};
					if (mode_reg.legacy_err && mode_reg.stack32) begin
						req.be = `SU_BE_HALF;
					end else begin
						req.be = `SU_BE_WORD;
					end
				end else begin
					req.wdata = {`SU_ZERO_HALF, cmd_reg.selector};
					if (mode_reg.alt_sizing) begin
						req.be = op_be(cmd_reg.opsize32);
					end else begin
						req.be = `SU_BE_HALF;
					end
				end
			end
			ST_PUSH2: begin
				req.write = 1'b1;
				req.wdata = cmd_reg.value;
				req.be    = op_be(cmd_reg.opsize32);
			end
			ST_READ: begin
				if ((cmd_reg.op == OP_POP_SEL) && !mode_reg.alt_sizing) begin
					req.be = `SU_BE_HALF;
				end else begin
					req.be = op_be(cmd_reg.opsize32);
				end
			end
			ST_WRITE: begin
				req.write     = 1'b1;
				req.stack_seg = cmd_reg.dest_sp_base;
				req.wdata     = data_reg;
				req.be        = op_be(cmd_reg.opsize32);
				// pointer already advanced, so a wrapped pointer lands at zero plus index
				if (cmd_reg.dest_sp_base) begin
					req.addr = sp_addr + cmd_reg.dest_addr;
				end else begin
					req.addr = cmd_reg.dest_addr;
				end
			end
			default: begin
				req.be = `SU_BE_NONE;
			end
		endcase
	end

	stack_limit_check u_check (
		.base_i   (req.addr),
		.be_i     (req.be),
		.limit_i  (mode_reg.limit),
		.enable_i (access && req.stack_seg),
		.fault_o  (lim_fault)
	);

	// a failed limit check never reaches memory
	always_comb begin
		mem_req_o       = req;
		mem_req_o.valid = access && !lim_fault;
	end

	// ==================================================================
	// sequencer
	always_comb begin
		state_next = state_reg;
		cmd_next   = cmd_reg;
		mode_next  = mode_reg;
		sp_next    = sp_reg;
		save_next  = save_reg;
		data_next  = data_reg;
		fcode_next = fcode_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cmd_valid_i) begin
					cmd_next   = cmd_i;
					mode_next  = mode_i;
					save_next  = sp_reg;
					fcode_next = FLT_NONE;
					case (cmd_i.op)
						OP_FAR_CALL: begin
							state_next = ST_BRCHK;
						end
						OP_POP_SEL, OP_POP_MEM: begin
							state_next = ST_READ;
						end
						OP_PUSH_ERR: begin
							sp_next    = sp_step(sp_reg, `SU_DELTA_ERR, 1'b1, mode_i.stack32);
							state_next = ST_PUSH;
						end
						default: begin
							sp_next    = sp_step(sp_reg, op_delta(cmd_i.opsize32), 1'b1,
							                     mode_i.stack32);
							state_next = ST_PUSH;
						end
					endcase
				end else if (sp_wr_i) begin
					sp_next = sp_wr_data_i;
				end
			end
			ST_BRCHK: begin
				if (br_done_i) begin
					if (branch_fault) begin
						fcode_next = FLT_BRANCH;
						state_next = ST_FAULT;
					end else begin
						sp_next    = sp_step(sp_reg, op_delta(cmd_reg.opsize32), 1'b1,
						                     mode_reg.stack32);
						state_next = ST_PUSH;
					end
				end
			end
			ST_PUSH: begin
				if (mem_ack_i) begin
					if (cmd_reg.op == OP_FAR_CALL) begin
						sp_next    = sp_step(sp_reg, op_delta(cmd_reg.opsize32), 1'b1,
						                     mode_reg.stack32);
						state_next = ST_PUSH2;
					end else begin
						state_next = ST_DONE;
					end
				end
			end
			ST_PUSH2: begin
				if (mem_ack_i) begin
					state_next = ST_DONE;
				end
			end
			ST_READ: begin
				if (mem_ack_i) begin
					data_next = (req.be == `SU_BE_HALF) ?
					            {`SU_ZERO_HALF, mem_rdata_i[15:0]} : mem_rdata_i;
					sp_next   = sp_step(sp_reg, op_delta(cmd_reg.opsize32), 1'b0,
					                    mode_reg.stack32);
					state_next = (cmd_reg.op == OP_POP_MEM) ? ST_WRITE : ST_DONE;
				end
			end
			ST_WRITE: begin
				if (mem_ack_i) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE, ST_FAULT: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// any access fault backs the pointer up so the instruction can restart
		if (access && (lim_fault || mem_fault_i)) begin
			sp_next    = save_reg;
			data_next  = data_reg;
			fcode_next = lim_fault ? FLT_LIMIT : FLT_PAGE;
			state_next = ST_FAULT;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			cmd_reg   <= '0;
			mode_reg  <= '0;
			sp_reg    <= `SU_SP_RESET;
			save_reg  <= `SU_SP_RESET;
			data_reg  <= `SU_DATA_RESET;
			fcode_reg <= FLT_NONE;
		end else begin
			state_reg <= state_next;
			cmd_reg   <= cmd_next;
			mode_reg  <= mode_next;
			sp_reg    <= sp_next;
			save_reg  <= save_next;
			data_reg  <= data_next;
			fcode_reg <= fcode_next;
		end
	end

	// ==================================================================
	// outputs
	assign cmd_ready_o  = (state_reg == ST_IDLE);
	assign br_req_o     = (state_reg == ST_BRCHK);
	assign done_o       = (state_reg == ST_DONE) || (state_reg == ST_FAULT);
	assign fault_o      = (state_reg == ST_FAULT);
	assign fault_code_o = fcode_reg;
	assign sp_o         = sp_reg;
	assign pop_data_o   = data_reg;

endmodule : stack_push_pop_unit
`default_nettype wire

/* File: design/stack_unit_defines.svh */
// constants of the stack push/pop unit
`ifndef STACK_UNIT_DEFINES_SVH
`define STACK_UNIT_DEFINES_SVH

// ==================================================================
// reset values
`define SU_SP_RESET     32'h0000_0000
`define SU_DATA_RESET   32'h0000_0000

// ==================================================================
// access sizes and byte lanes
`define SU_SLOT_BYTES   4
`define SU_BE_WORD      4'hf
`define SU_BE_HALF      4'h3
`define SU_BE_NONE      4'h0
`define SU_DELTA_WORD   32'h0000_0004
`define SU_DELTA_HALF   32'h0000_0002
`define SU_DELTA_ERR    32'h0000_0004
`define SU_ZERO_HALF    16'h0000

`endif

/* File: design/stack_unit_pkg.sv */
// types of the stack push/pop unit
package stack_unit_pkg;

	// ==================================================================
	// commands, fault codes and states
	typedef enum logic [2:0] {
		OP_PUSH_SEL = 3'h0,
		OP_POP_SEL  = 3'h1,
		OP_PUSH_ERR = 3'h2,
		OP_FAR_CALL = 3'h3,
		OP_POP_MEM  = 3'h4
	} stack_op_t;

	typedef enum logic [1:0] {
		FLT_NONE   = 2'h0,
		FLT_BRANCH = 2'h1,
		FLT_LIMIT  = 2'h2,
		FLT_PAGE   = 2'h3
	} fault_t;

	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_BRCHK = 8'h02,
		ST_PUSH  = 8'h04,
		ST_PUSH2 = 8'h08,
		ST_READ  = 8'h10,
		ST_WRITE = 8'h20,
		ST_DONE  = 8'h40,
		ST_FAULT = 8'h80
	} stack_state_t;

	// ==================================================================
	// carriers
	typedef struct packed {
		stack_op_t   op;
		logic        opsize32;
		logic [15:0] selector;
		logic [31:0] value;
		logic        dest_sp_base;
		logic [31:0] dest_addr;
	} stack_cmd_t;

	typedef struct packed {
		logic        stack32;
		logic        alt_sizing;
		logic        legacy_err;
		logic [31:0] limit;
	} stack_mode_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        stack_seg;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} mem_req_t;

endpackage : stack_unit_pkg

/* File: design/stack_limit_check.sv */
// per-byte segment limit check of one stack access
`timescale 1ns/100ps
`default_nettype none
`include "stack_unit_defines.svh"

module stack_limit_check (
	input  wire logic [31:0] base_i,
	input  wire logic [3:0]  be_i,
	input  wire logic [31:0] limit_i,
	input  wire logic        enable_i,
	output logic             fault_o
);

	logic [3:0] over;

	// ==================================================================
	// each enabled byte lane, carry past 4 GB counts as over the limit
	for (genvar i = 0; i < `SU_SLOT_BYTES; i++) begin : g_byte
		logic [32:0] off;
		assign off     = {1'b0, base_i} + 33'(i);
		assign over[i] = be_i[i] && (off > {1'b0, limit_i});
	end

	assign fault_o = enable_i && (|over);

endmodule : stack_limit_check
`default_nettype wire

/* File: verif/stack_unit_properties.sv */
// port assertions of the stack push/pop unit
`timescale 1ns/100ps
`default_nettype none
module stack_unit_properties
	import stack_unit_pkg::*;
(
	input wire logic        mclk_i,
	input wire logic        reset_n_i,
	input wire logic        cmd_valid_i,
	input wire stack_cmd_t  cmd_i,
	input wire logic        cmd_ready_o,
	input wire stack_mode_t mode_i,
	input wire mem_req_t    mem_req_o,
	input wire logic        br_req_o,
	input wire logic        br_done_i,
	input wire logic        br_limit_viol_i,
	input wire logic        br_rights_viol_i,
	input wire logic        done_o,
	input wire logic        fault_o,
	input wire fault_t      fault_code_o,
	input wire logic [31:0] sp_o
);
	// ==========================================
	// command capture
	logic        go;
	stack_op_t   op_q;
	logic        w_q;
	logic [31:0] sp_q;
	assign go = cmd_valid_i && cmd_ready_o;
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			op_q <= OP_PUSH_SEL;
			w_q  <= 1'b0;
			sp_q <= 32'h0000_0000;
		end else if (go) begin
			op_q <= cmd_i.op;
			w_q  <= cmd_i.opsize32;
			sp_q <= sp_o;
		end
	end
	// ==========================================
	// properties
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_brbad;
		br_req_o && br_done_i && (br_limit_viol_i || br_rights_viol_i);
	endsequence
	property p_brfirst;
		go && cmd_i.op == OP_FAR_CALL |=> br_req_o && !mem_req_o.valid;
	endproperty
	a_brfirst: assert property (p_brfirst) else $error("far call pushed first");
	property p_brflt;
		s_brbad |=> done_o && fault_o && fault_code_o == FLT_BRANCH;
	endproperty
	a_brflt: assert property (p_brflt) else $error("branch fault missed");
	property p_brsp;
		s_brbad |=> !mem_req_o.valid ##1 cmd_ready_o && !mem_req_o.valid;
	endproperty
	a_brsp: assert property (p_brsp) else $error("push after branch fault");
	property p_push;
		go && cmd_i.op == OP_PUSH_SEL && mode_i.stack32 && mode_i.limit == 32'hffff_ffff
		|=> sp_o == $past(sp_o) - ($past(cmd_i.opsize32) ? 32'h0000_0004 : 32'h0000_0002);
	endproperty
	a_push: assert property (p_push) else $error("push step wrong");
	property p_sel_dflt;
		mem_req_o.valid && (op_q == OP_PUSH_SEL || op_q == OP_POP_SEL) && !mode_i.alt_sizing
		|-> mem_req_o.be == 4'h3;
	endproperty
	a_sel_dflt: assert property (p_sel_dflt) else $error("selector lanes wrong");
	property p_sel_alt;
		mem_req_o.valid && op_q == OP_PUSH_SEL && mode_i.alt_sizing && w_q
		|-> mem_req_o.be == 4'hf && mem_req_o.wdata[31:16] == 16'h0000;
	endproperty
	a_sel_alt: assert property (p_sel_alt) else $error("wide selector push wrong");
	property p_err;
		mem_req_o.valid && op_q == OP_PUSH_ERR |-> mem_req_o.wdata[31:16] == 16'h0000
		&& mem_req_o.be == ((mode_i.legacy_err && mode_i.stack32) ? 4'h3 : 4'hf);
	endproperty
	a_err: assert property (p_err) else $error("error code write wrong");
	property p_fltrest;
		fault_o |-> done_o ##1 sp_o == sp_q;
	endproperty
	a_fltrest: assert property (p_fltrest) else $error("pointer not restored");
endmodule : stack_unit_properties
`default_nettype wire

/* File: verif/stack_mem_model.sv */
// memory and branch-check partner of the stack push/pop unit
`timescale 1ns/100ps
`default_nettype none
module stack_mem_model
	import stack_unit_pkg::*;
(
	input  wire logic       clk_i,
	input  wire mem_req_t   req_i,
	input  wire logic       slow_i,
	input  wire logic       fail_i,
	input  wire logic [1:0] skip_i,
	output logic            ack_o,
	output logic            fault_o,
	output logic [31:0]     rdata_o,
	input  wire logic       br_req_i,
	input  wire logic       lim_i,
	input  wire logic       acc_i,
	output logic            br_done_o,
	output logic            lim_o,
	output logic            acc_o
);
	logic [7:0] mem [int];
	int         n_acc = 0;
	logic       waited = 0;
	initial {ack_o, fault_o, rdata_o, br_done_o, lim_o, acc_o} = '0;
	// ==========================================
	// answers; data lines carry noise outside an answer
	always @(posedge clk_i) begin
		ack_o   <= 1'b0;
		fault_o <= 1'b0;
		rdata_o <= $urandom;
		if (req_i.valid && !ack_o && !fault_o) begin
			if (slow_i && !waited) begin
				waited = 1;
			end else begin
				waited = 0;
				if (fail_i && n_acc == int'(skip_i)) begin
					fault_o <= 1'b1;
				end else begin
					ack_o <= 1'b1;
					for (int i = 0; i < 4; i++) begin
						if (req_i.write && req_i.be[i]) mem[req_i.addr + i] = req_i.wdata[8*i +: 8];
						rdata_o[8*i +: 8] <= mem.exists(req_i.addr + i) ? mem[req_i.addr + i] : 8'h5a;
					end
				end
				n_acc++;
			end
		end
		if (!fail_i) n_acc = 0;
		br_done_o <= br_req_i && !br_done_o;
		lim_o     <= (br_req_i && !br_done_o) ? lim_i : 1'($urandom);
		acc_o     <= (br_req_i && !br_done_o) ? acc_i : 1'($urandom);
	end
endmodule : stack_mem_model
`default_nettype wire

/* File: verif/stack_push_pop_unit_test.sv */
// self-checking bench of the stack push/pop unit
`timescale 1ns/100ps
`default_nettype none
module stack_push_pop_unit_test
	import stack_unit_pkg::*;
;
	logic        clk = 0, rst_n = 0, cv = 0, spw = 0, slow = 0, mf = 0, bl = 0, ba = 0;
	logic [1:0]  skip = 1;
	logic [31:0] spd = 0, sp, pd, rd;
	stack_cmd_t  c = '0;
	stack_mode_t md = '0;
	mem_req_t    rq;
	fault_t      fc;
	logic        rdy, ack, mflt, brq, bdn, blv, brv, dn, flt;
	int          fails = 0, checks_done = 0, e, b;
	logic [7:0]  em [int];
	initial forever #4 clk = ~clk;
	stack_push_pop_unit u_dut (.mclk_i(clk), .reset_n_i(rst_n), .cmd_valid_i(cv), .cmd_i(c),
		.cmd_ready_o(rdy), .mode_i(md), .sp_wr_i(spw), .sp_wr_data_i(spd), .mem_req_o(rq),
		.mem_ack_i(ack), .mem_rdata_i(rd), .mem_fault_i(mflt), .br_req_o(brq), .br_done_i(bdn),
		.br_limit_viol_i(blv), .br_rights_viol_i(brv), .done_o(dn), .fault_o(flt),
		.fault_code_o(fc), .sp_o(sp), .pop_data_o(pd));
	stack_mem_model u_mem (.clk_i(clk), .req_i(rq), .slow_i(slow), .fail_i(mf), .skip_i(skip),
		.ack_o(ack), .fault_o(mflt), .rdata_o(rd), .br_req_i(brq), .lim_i(bl), .acc_i(ba),
		.br_done_o(bdn), .lim_o(blv), .acc_o(brv));
	// ==========================================
	// compare and drive tasks
	task automatic chk(input logic [31:0] g, x);
		checks_done++;
		if (g !== x) begin
			fails++;
			$display("unexpected %0t got %h want %h", $time, g, x);
		end
	endtask : chk
	task automatic chk_mem(input int a, n);
		for (int i = 0; i < n; i++) chk(32'(u_mem.mem[a + i]), 32'(em[a + i]));
	endtask : chk_mem
	task automatic pre(input int a, n);
		for (int i = 0; i < n; i++) begin
			// random fill, so a missing or misplaced write shows up
			em[a + i] = 8'($urandom);
			u_mem.mem[a + i] = em[a + i];
		end
	endtask : pre
	task automatic put(input int a, input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++) em[a + i] = v[8*i +: 8];
	endtask : put
	task automatic ld(input int a);
		spd = a;
		spw = 1;
		@(posedge clk);
		#1 spw = 0;
		e = a;
	endtask : ld
	task automatic run(input stack_op_t op, input logic w, input fault_t ef);
		int n;
		c.op = op;
		c.opsize32 = w;
		c.selector = 16'($urandom);
		c.value = $urandom;
		slow = 1'($urandom);
		cv = 1;
		@(posedge clk);
		#1 cv = 0;
		for (n = 0; n < 40 && dn !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 40) begin
			fails++;
			report_and_stop();
		end
		chk(32'(fc), 32'(ef));
		chk(32'(flt), 32'(ef != FLT_NONE));
		@(posedge clk);
		#1;
	endtask : run
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	// ==========================================
	// scenarios
	initial begin
		void'($urandom(32'h5fb8));
		md.stack32 = 1;
		md.limit = 32'hffff_ffff;
		repeat (20) @(posedge clk);
		#1 rst_n = 1;
		repeat (4) @(posedge clk);
		#1;
		for (int k = 0; k < 4; k++) begin
			md.alt_sizing = k[1];
			ld(256 + k * 16);
			pre(e - 4, 8);
			run(OP_PUSH_SEL, k[0], FLT_NONE);
			e -= k[0] ? 4 : 2;
			put(e, {16'h0000, c.selector}, k == 3 ? 4 : 2);
			chk(sp, e);
			chk_mem(e, 4);
			run(OP_POP_SEL, k[0], FLT_NONE);
			chk(pd, {em[e + 3], em[e + 2], em[e + 1], em[e]} & {{16{k == 3}}, 16'hffff});
			e += k[0] ? 4 : 2;
			chk(sp, e);
		end
		md.alt_sizing = 0;
		for (int k = 0; k < 2; k++) begin
			md.legacy_err = k[0];
			pre(e - 4, 4);
			run(OP_PUSH_ERR, 1'b1, FLT_NONE);
			e -= 4;
			put(e, {16'h0000, c.value[15:0]}, k ? 2 : 4);
			chk(sp, e);
			chk_mem(e, 4);
		end
		md.legacy_err = 0;
		// target faults, then a page fault after the first push
		for (int k = 0; k < 4; k++) begin
			bl = k == 1;
			ba = k == 2;
			mf = k == 3;
			b = e;
			pre(e - 8, 8);
			run(OP_FAR_CALL, 1'b1, k == 0 ? FLT_NONE : k == 3 ? FLT_PAGE : FLT_BRANCH);
			if (k == 0) e -= 8;
			if (k == 0 || k == 3) put(b - 4, {16'h0000, c.selector}, 2);
			if (k == 0) put(b - 8, c.value, 4);
			chk(sp, e);
			chk_mem(b - 8, 8);
		end
		{bl, ba, mf} = '0;
		for (int k = 0; k < 2; k++) begin
			md.alt_sizing = k[0];
			md.limit = e - 3;
			b = e;
			pre(e - 4, 4);
			run(OP_PUSH_SEL, 1'b1, k ? FLT_LIMIT : FLT_NONE);
			if (k == 0) e -= 4;
			if (k == 0) put(e, {16'h0000, c.selector}, 2);
			chk(sp, e);
			chk_mem(b - 4, 4);
		end
		md = '0;
		md.limit = 32'h0000_ffff;
		c.dest_sp_base = 1;
		for (int k = 0; k < 2; k++) begin
			ld(k ? 32'h0000_fffc : 32'h0000_fffe);
			c.dest_addr = $urandom_range(32, 64);
			pre(e, k ? 4 : 2);
			pre(c.dest_addr, 4);
			run(OP_POP_MEM, k[0], FLT_NONE);
			for (int i = 0; i < (k ? 4 : 2); i++) em[c.dest_addr + i] = em[e + i];
			chk(sp, 32'h0000_0000);
			chk_mem(c.dest_addr, 4);
		end
		// plain destination offset, outside the stack segment
		c.dest_sp_base = 0;
		ld(32'h0000_0100);
		c.dest_addr = 32'h0000_0080;
		pre(e, 4);
		pre(c.dest_addr, 4);
		run(OP_POP_MEM, 1'b1, FLT_NONE);
		for (int i = 0; i < 4; i++) em[c.dest_addr + i] = em[e + i];
		chk(sp, e + 4);
		chk_mem(c.dest_addr, 4);
		report_and_stop();
	end
endmodule : stack_push_pop_unit_test
bind stack_push_pop_unit stack_unit_properties u_prop (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
	.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .mode_i(mode_i),
	.mem_req_o(mem_req_o), .br_req_o(br_req_o), .br_done_i(br_done_i),
	.br_limit_viol_i(br_limit_viol_i), .br_rights_viol_i(br_rights_viol_i), .done_o(done_o),
	.fault_o(fault_o), .fault_code_o(fault_code_o), .sp_o(sp_o));
`default_nettype wire
